// ==== pkg/tdm_slot_pkg.sv ====
// shared constants, register layout and types of the tdm slot port
package tdm_slot_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RX_CFG    = 8'h00;
	localparam logic [7:0] ADDR_TX_CFG    = 8'h04;
	localparam logic [7:0] ADDR_TX_SLOT_A = 8'h08;
	localparam logic [7:0] ADDR_TX_SLOT_B = 8'h0C;
	localparam logic [7:0] ADDR_TX_DATA_A = 8'h10;
	localparam logic [7:0] ADDR_TX_DATA_B = 8'h14;
	localparam logic [7:0] ADDR_TX_DATA_C = 8'h18;
	localparam logic [7:0] ADDR_PLAYBACK  = 8'h1C;
	localparam logic [7:0] ADDR_STATUS    = 8'h20;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RX_CFG_RESET    = 32'h0000_0506;
	localparam logic [31:0] TX_CFG_RESET    = 32'h0000_0033;
	localparam logic [31:0] TX_SLOT_A_RESET = 32'h0604_0200;
	localparam logic [31:0] TX_SLOT_B_RESET = 32'h0000_0807;

	// ----------------------------------------------------------------
	// field encodings and sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] SLEN_16 = 2'h0;
	localparam logic [1:0] SLEN_24 = 2'h1;
	localparam logic [1:0] WLEN_16 = 2'h0;
	localparam logic [1:0] WLEN_20 = 2'h1;
	localparam logic [1:0] WLEN_24 = 2'h2;
	localparam logic [1:0] SRC_ADDR  = 2'h0;
	localparam logic [1:0] SRC_LEFT  = 2'h1;
	localparam logic [1:0] SRC_RIGHT = 2'h2;

	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_20 = 6'h14;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [5:0] BITS_32 = 6'h20;

	localparam int         STREAM_COUNT   = 6;
	localparam int         STREAM_SUPPLY  = 3;
	localparam int         TWO_SLOT_LIMIT = 3;
	localparam int         LANE_BITS      = 8;
	localparam int         SLOT_FIELD_W   = 6;
	localparam int         SLOTS_PER_REG  = 4;
	localparam logic [8:0] RX_COUNT_MAX   = 9'h1FF;
	localparam logic [9:0] TX_POS_MAX     = 10'h3FF;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		AHB_IDLE = 1'b0,
		AHB_DATA = 1'b1
	} ahb_state_t;

	typedef struct packed {
		logic [9:0] reserved;
		logic [3:0] right_slot;
		logic [3:0] left_slot;
		logic [1:0] playback_source_config;
		logic       justify_right;
		logic [1:0] receive_word_length;
		logic [1:0] receive_slot_length;
		logic [4:0] offset;
		logic       start_on_fall;
		logic       capture_fall;
	} rx_cfg_t;

	typedef struct packed {
		logic [18:0] reserved;
		logic [5:0]  stream_enable;
		logic        supply_stream_length;
		logic        keeper_on;
		logic        fill_hiz;
		logic [2:0]  offset;
		logic        launch_fall;
	} tx_cfg_t;

endpackage

// ==== hw/tdm_slot_port.sv ====
// tdm receive and transmit slot port with an ahb-lite register slave
// Function
// RL1: capture sync and data on rising edge if edge bit 0, else falling.
// RL2: receive slot 0 starts 0..31 bit clocks after frame sync transition.
// RL3: receive slot length 16, 24 or 32 bits; code 11 reserved.
// RL4: receive sample width 16, 20, 24 or 32 bits.
// RL5: sample left-justified in slot by default, right-justified when bit set.
// RL6: playback from address slot, left, right, or (L+R)/2 downmix.
// RL7: left and right slot fields are 4 bits, reset to 0.
// RL8: slot beyond frame end yields a null, muted sample.
// RL9: launch output on rising edge if edge bit 0, falling if 1.
// RL10: transmit slot 0 starts 0..7 bit clocks after frame start.
// RL11: unused output bits drive 0 or float, per fill bit.
// RL12: keeper enable holds output level while undriven; 0 turns it off.
// RL13: transmit slots are 8 bits; 16-bit streams use two slots.
// RL14: supply stream sent as 16-bit left-justified or top 8 bits.
// RL15: temperature and gain streams take one 8-bit slot each.
// RL16: slot field names MSB slot; low byte follows in next slot.
// RL17: each stream has an enable, reset off; disabled streams use no slot.
// RL18: host keeps enabled stream slots from overlapping; overlap is undefined.
// RL19: stream running past frame end is cut at the boundary.
// RL20: voltage slot field 6 bits, reset 0.
// RL21: current slot field 6 bits, reset 2.
// RL22: decimated pulse slot field 6 bits, reset 4.
// RL23: frame starts on sync rise if polarity bit 0, fall if 1.
// RL24: supply length bit 0 truncates to 8 bits, 1 gives 16 bits.
// RL25: transmit slot N sits offset plus 8N bit clocks after frame start.
// RL26: host supplies steady bit clock and periodic frame sync.
module tdm_slot_port (
	input  wire logic        hclk,               // bus and block clock
	input  wire logic        hresetn,            // async reset, active low
	input  wire logic        hsel,               // slave select
	input  wire logic [31:0] haddr,              // byte address
	input  wire logic [1:0]  htrans,             // transfer type
	input  wire logic        hwrite,             // write when high
	input  wire logic [2:0]  hsize,              // transfer size
	input  wire logic [31:0] hwdata,             // write data
	input  wire logic        hready,             // bus ready in
	output logic             hreadyout,          // slave ready
	output logic [31:0]      hrdata,             // read data
	output logic             hresp,              // always okay
	input  wire logic        serial_bit_clock,   // link bit clock pin
	input  wire logic        frame_sync,         // link frame sync pin
	input  wire logic        serial_data_in,     // link data in pin
	input  wire logic [2:0]  address_select,     // address offset strap
	output logic             serial_data_out,    // link data out level
	output logic             serial_data_out_en, // link data out enable
	output logic             bus_keeper_enable,  // weak keeper on
	output logic [31:0]      playback_sample,    // chosen sample, msb aligned
	output logic             playback_valid      // sample strobe
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	tdm_slot_pkg::ahb_state_t ahb_state;
	tdm_slot_pkg::rx_cfg_t    rx_cfg;
	tdm_slot_pkg::tx_cfg_t    tx_cfg;
	logic [7:0]  ahb_addr;
	logic        ahb_write;
	logic [31:0] slot_a;
	logic [31:0] slot_b;
	logic [31:0] data_a;
	logic [31:0] data_b;
	logic [31:0] data_c;
	logic [31:0] read_mux;

	logic [2:0]  clk_sync;
	logic [1:0]  fs_sync;
	logic [1:0]  din_sync;
	logic [2:0]  addr_meta;
	logic [2:0]  addr_s;
	logic        clk_rise;
	logic        clk_fall;

	logic        cap_ev;
	logic        fs_prev;
	logic        rx_start;
	logic        frame_seen;
	logic [8:0]  rx_count;
	logic [8:0]  next_count;
	logic        rx_in;
	logic        next_in;
	logic [4:0]  rx_slot;
	logic [4:0]  next_slot;
	logic [5:0]  rx_bis;
	logic [5:0]  next_bis;
	logic [5:0]  slen;
	logic [5:0]  wlen;
	logic [5:0]  take_n;
	logic        take;
	logic        slot_end;
	logic [3:0]  ch_sel   [2];
	logic        ch_hit   [2];
	logic [31:0] shreg    [2];
	logic [31:0] next_sh  [2];
	logic [31:0] aligned  [2];
	logic [31:0] hold     [2];
	logic        done     [2];
	logic [31:0] ch_out   [2];
	logic [32:0] mix_sum;
	logic [31:0] chosen;
	logic [8:0]  frame_bits;
	logic [15:0] frame_count;

	logic        launch_ev;
	logic        tx_pending;
	logic        tx_active;
	logic        restart;
	logic [9:0]  tpos;
	logic [9:0]  next_tpos;
	logic [9:0]  rel;
	logic        tx_in;
	logic [6:0]  tslot;
	logic [2:0]  tb;
	logic [5:0]  stream_slot [tdm_slot_pkg::STREAM_COUNT];
	logic [15:0] live_word   [tdm_slot_pkg::STREAM_COUNT];
	logic [15:0] snap_word   [tdm_slot_pkg::STREAM_COUNT];
	logic        tx_hit;
	logic        tx_bit;

	// ----------------------------------------------------------------
	// pin synchronisers and bit clock edges
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_sync  <= 3'h0;
			fs_sync   <= 2'h0;
			din_sync  <= 2'h0;
			addr_meta <= 3'h0;
			addr_s    <= 3'h0;
		end else begin
			clk_sync  <= {clk_sync[1:0], serial_bit_clock};
			fs_sync   <= {fs_sync[0], frame_sync};
			din_sync  <= {din_sync[0], serial_data_in};
			addr_meta <= address_select;
			addr_s    <= addr_meta;
		end
	end

	// stage 1 and 2 of clk_sync form the synchroniser; stage 2 vs 3 is the edge
	assign clk_rise = clk_sync[1] & ~clk_sync[2];
	assign clk_fall = ~clk_sync[1] & clk_sync[2];

	// ----------------------------------------------------------------
	// ahb-lite slave: one wait state on every transfer
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ahb_state <= tdm_slot_pkg::AHB_IDLE;
			hreadyout <= 1'b1;
			ahb_addr  <= 8'h00;
			ahb_write <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0;
			case (ahb_state)
				tdm_slot_pkg::AHB_IDLE: begin
					if (hsel && htrans[1] && hready) begin
						ahb_addr  <= haddr[7:0];
						ahb_write <= hwrite;
						ahb_state <= tdm_slot_pkg::AHB_DATA;
						hreadyout <= 1'b0;
					end
				end
				tdm_slot_pkg::AHB_DATA: begin
					ahb_state <= tdm_slot_pkg::AHB_IDLE;
					hreadyout <= 1'b1;
				end
				default: begin
					ahb_state <= tdm_slot_pkg::AHB_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_cfg <= tdm_slot_pkg::rx_cfg_t'(tdm_slot_pkg::RX_CFG_RESET);
			tx_cfg <= tdm_slot_pkg::tx_cfg_t'(tdm_slot_pkg::TX_CFG_RESET);
			slot_a <= tdm_slot_pkg::TX_SLOT_A_RESET;
			slot_b <= tdm_slot_pkg::TX_SLOT_B_RESET;
			data_a <= 32'h0000_0000;
			data_b <= 32'h0000_0000;
			data_c <= 32'h0000_0000;
		end else if (ahb_state == tdm_slot_pkg::AHB_DATA && ahb_write) begin
			case (ahb_addr)
				tdm_slot_pkg::ADDR_RX_CFG:    rx_cfg <= tdm_slot_pkg::rx_cfg_t'(hwdata);
				tdm_slot_pkg::ADDR_TX_CFG:    tx_cfg <= tdm_slot_pkg::tx_cfg_t'(hwdata);
				tdm_slot_pkg::ADDR_TX_SLOT_A: slot_a <= hwdata;
				tdm_slot_pkg::ADDR_TX_SLOT_B: slot_b <= hwdata;
				tdm_slot_pkg::ADDR_TX_DATA_A: data_a <= hwdata;
				tdm_slot_pkg::ADDR_TX_DATA_B: data_b <= hwdata;
				tdm_slot_pkg::ADDR_TX_DATA_C: data_c <= hwdata;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (ahb_addr)
			tdm_slot_pkg::ADDR_RX_CFG:    read_mux = {10'h000, rx_cfg[21:0]};
			tdm_slot_pkg::ADDR_TX_CFG:    read_mux = {19'h0_0000, tx_cfg[12:0]};
			tdm_slot_pkg::ADDR_TX_SLOT_A: read_mux = slot_a & 32'h3F3F_3F3F;
			tdm_slot_pkg::ADDR_TX_SLOT_B: read_mux = slot_b & 32'h0000_3F3F;
			tdm_slot_pkg::ADDR_TX_DATA_A: read_mux = data_a;
			tdm_slot_pkg::ADDR_TX_DATA_B: read_mux = data_b & 32'h0FFF_FFFF;
			tdm_slot_pkg::ADDR_TX_DATA_C: read_mux = data_c & 32'h0000_FFFF;
			tdm_slot_pkg::ADDR_PLAYBACK:  read_mux = playback_sample;
			tdm_slot_pkg::ADDR_STATUS:    read_mux = {7'h00, frame_bits, frame_count};
			default:                      read_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (ahb_state == tdm_slot_pkg::AHB_DATA && !ahb_write) begin
			hrdata <= read_mux;
		end
	end

	// ----------------------------------------------------------------
	// receive framing
	// ----------------------------------------------------------------
	function automatic logic [5:0] slot_bits(input logic [1:0] code);
		case (code)
			tdm_slot_pkg::SLEN_16: slot_bits = tdm_slot_pkg::BITS_16;
			tdm_slot_pkg::SLEN_24: slot_bits = tdm_slot_pkg::BITS_24;
			default:               slot_bits = tdm_slot_pkg::BITS_32;
		endcase
	endfunction

	function automatic logic [5:0] word_bits(input logic [1:0] code);
		case (code)
			tdm_slot_pkg::WLEN_16: word_bits = tdm_slot_pkg::BITS_16;
			tdm_slot_pkg::WLEN_20: word_bits = tdm_slot_pkg::BITS_20;
			tdm_slot_pkg::WLEN_24: word_bits = tdm_slot_pkg::BITS_24;
			default:               word_bits = tdm_slot_pkg::BITS_32;
		endcase
	endfunction

	always_comb begin
		// RL1: capture edge select
		cap_ev = rx_cfg.capture_fall ? clk_fall : clk_rise;
		// RL23: frame start polarity
		rx_start = rx_cfg.start_on_fall ? (fs_prev & ~fs_sync[1]) : (~fs_prev & fs_sync[1]);
		next_count = rx_start ? 9'h000 :
			((rx_count == tdm_slot_pkg::RX_COUNT_MAX) ? rx_count : rx_count + 9'h001);
		// RL3: slot length
		slen = slot_bits(rx_cfg.receive_slot_length);
		// RL4: word length, clipped to the slot
		wlen   = word_bits(rx_cfg.receive_word_length);
		take_n = (wlen > slen) ? slen : wlen;
		// RL2: slot 0 begins offset bit clocks after the sync transition
		next_in = (next_count == {4'h0, rx_cfg.offset}) | (rx_in & ~rx_start);
		if (next_count == {4'h0, rx_cfg.offset}) begin
			next_slot = 5'h00;
			next_bis  = 6'h00;
		end else if (rx_bis == slen - 6'h01) begin
			next_slot = (rx_slot == 5'h1F) ? rx_slot : rx_slot + 5'h01;
			next_bis  = 6'h00;
		end else begin
			next_slot = rx_slot;
			next_bis  = rx_bis + 6'h01;
		end
		// RL5: left or right justification within the slot
		take     = rx_cfg.justify_right ? (next_bis >= slen - take_n) : (next_bis < take_n);
		slot_end = next_bis == slen - 6'h01;
		// RL6: first channel is the address slot or the left slot
		// RL7: 4-bit slot selects
		ch_sel[0] = (rx_cfg.playback_source_config == tdm_slot_pkg::SRC_ADDR) ?
			{1'b0, addr_s} : rx_cfg.left_slot;
		ch_sel[1] = rx_cfg.right_slot;
		for (int c = 0; c < 2; c++) begin
			ch_hit[c]  = next_in & (next_slot == {1'b0, ch_sel[c]});
			next_sh[c] = (next_bis == 6'h00) ? 32'h0000_0000 : shreg[c];
			if (take) begin
				next_sh[c] = {next_sh[c][30:0], din_sync[1]};
			end
			aligned[c] = next_sh[c] << (tdm_slot_pkg::BITS_32 - take_n);
			// RL8: an unfinished slot gives a muted sample
			ch_out[c] = done[c] ? hold[c] : 32'h0000_0000;
		end
		mix_sum = {ch_out[0][31], ch_out[0]} + {ch_out[1][31], ch_out[1]};
		// RL6: source select and (L+R)/2 downmix
		case (rx_cfg.playback_source_config)
			tdm_slot_pkg::SRC_ADDR:  chosen = ch_out[0];
			tdm_slot_pkg::SRC_LEFT:  chosen = ch_out[0];
			tdm_slot_pkg::SRC_RIGHT: chosen = ch_out[1];
			default:                 chosen = mix_sum[32:1];
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fs_prev  <= 1'b0;
			rx_count <= tdm_slot_pkg::RX_COUNT_MAX;
			rx_in    <= 1'b0;
			rx_slot  <= 5'h1F;
			rx_bis   <= 6'h00;
		end else if (cap_ev) begin
			fs_prev  <= fs_sync[1];
			rx_count <= next_count;
			rx_in    <= next_in;
			rx_slot  <= next_slot;
			rx_bis   <= next_bis;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int c = 0; c < 2; c++) begin
				shreg[c] <= 32'h0000_0000;
				hold[c]  <= 32'h0000_0000;
				done[c]  <= 1'b0;
			end
		end else if (cap_ev) begin
			for (int c = 0; c < 2; c++) begin
				if (ch_hit[c]) begin
					shreg[c] <= next_sh[c];
				end
				// RL8: a new frame voids slots not completed in the old one
				if (rx_start) begin
					done[c] <= 1'b0;
				end else if (ch_hit[c] && slot_end) begin
					hold[c] <= aligned[c];
					done[c] <= 1'b1;
				end
			end
		end
	end

	// the sample of a frame is released when the next frame begins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_seen      <= 1'b0;
			playback_sample <= 32'h0000_0000;
			playback_valid  <= 1'b0;
			frame_bits      <= 9'h000;
			frame_count     <= 16'h0000;
		end else begin
			playback_valid <= cap_ev & rx_start & frame_seen;
			if (cap_ev && rx_start) begin
				frame_seen <= 1'b1;
				// RL26: frame length is only meaningful with a steady bit clock
				if (frame_seen) begin
					playback_sample <= chosen;
					frame_bits      <= rx_count + 9'h001;
					frame_count     <= frame_count + 16'h0001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit
	// ----------------------------------------------------------------
	always_comb begin
		// RL9: launch edge select
		launch_ev = tx_cfg.launch_fall ? clk_fall : clk_rise;
		restart   = tx_pending | (cap_ev & rx_start);
		next_tpos = restart ? 10'h000 :
			((tpos == tdm_slot_pkg::TX_POS_MAX) ? tpos : tpos + 10'h001);
		// RL10: slot 0 offset
		tx_in = next_tpos >= {7'h00, tx_cfg.offset};
		rel   = next_tpos - {7'h00, tx_cfg.offset};
		// RL25: slot N is offset plus 8N bit clocks into the frame
		tslot = rel[9:3];
		tb    = rel[2:0];
		// RL20: voltage slot field
		// RL21: current slot field
		// RL22: decimated pulse slot field
		for (int k = 0; k < tdm_slot_pkg::STREAM_COUNT; k++) begin
			if (k < tdm_slot_pkg::SLOTS_PER_REG) begin
				stream_slot[k] = slot_a[k * tdm_slot_pkg::LANE_BITS +: tdm_slot_pkg::SLOT_FIELD_W];
			end else begin
				stream_slot[k] = slot_b[(k - tdm_slot_pkg::SLOTS_PER_REG) * tdm_slot_pkg::LANE_BITS
					+: tdm_slot_pkg::SLOT_FIELD_W];
			end
		end
		// RL13: sense and pulse streams are 16-bit words
		live_word[0] = data_a[15:0];
		live_word[1] = data_a[31:16];
		live_word[2] = data_b[15:0];
		// RL14: supply stream left-justified; its high byte is the top eight bits
		live_word[3] = {data_b[27:16], 4'h0};
		// RL15: temperature and gain are single bytes
		live_word[4] = {data_c[7:0], 8'h00};
		live_word[5] = {data_c[15:8], 8'h00};
		tx_hit = 1'b0;
		tx_bit = 1'b0;
		// overlapping streams are simply or-ed; the host must avoid them
		for (int k = 0; k < tdm_slot_pkg::STREAM_COUNT; k++) begin
			// RL17: disabled streams take no slot
			if (tx_in && tx_cfg.stream_enable[k] && tslot == {1'b0, stream_slot[k]}) begin
				tx_hit = 1'b1;
				// RL16: most significant byte goes in the named slot
				tx_bit = tx_bit | (restart ? live_word[k][4'hF - {1'b0, tb}]
					: snap_word[k][4'hF - {1'b0, tb}]);
			end
			// RL24: second slot only for 16-bit supply length
			if (tx_in && tx_cfg.stream_enable[k] && tslot == {1'b0, stream_slot[k]} + 7'h01 &&
				(k < tdm_slot_pkg::TWO_SLOT_LIMIT ||
				(k == tdm_slot_pkg::STREAM_SUPPLY && tx_cfg.supply_stream_length))) begin
				tx_hit = 1'b1;
				tx_bit = tx_bit | (restart ? live_word[k][4'h7 - {1'b0, tb}]
					: snap_word[k][4'h7 - {1'b0, tb}]);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_pending <= 1'b0;
			tx_active  <= 1'b0;
			tpos       <= tdm_slot_pkg::TX_POS_MAX;
			for (int k = 0; k < tdm_slot_pkg::STREAM_COUNT; k++) begin
				snap_word[k] <= 16'h0000;
			end
		end else begin
			tx_pending <= launch_ev ? 1'b0 : restart;
			if (launch_ev) begin
				// RL19: a new frame restarts the count, cutting any stream in flight
				tpos <= next_tpos;
				if (restart) begin
					tx_active <= 1'b1;
					for (int k = 0; k < tdm_slot_pkg::STREAM_COUNT; k++) begin
						snap_word[k] <= live_word[k];
					end
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_data_out    <= 1'b0;
			serial_data_out_en <= 1'b0;
			bus_keeper_enable  <= 1'b1;
		end else begin
			// RL12: keeper follows its enable; the held level is the last one driven
			bus_keeper_enable <= tx_cfg.keeper_on;
			if (launch_ev) begin
				if (!(tx_active || restart)) begin
					serial_data_out_en <= 1'b0;
				end else if (tx_hit) begin
					serial_data_out    <= tx_bit;
					serial_data_out_en <= 1'b1;
				end else if (!tx_cfg.fill_hiz) begin
					// RL11: unused bits drive zero
					serial_data_out    <= 1'b0;
					serial_data_out_en <= 1'b1;
				end else begin
					// RL11: unused bits float
					serial_data_out_en <= 1'b0;
				end
			end
		end
	end

endmodule

// ==== testbench/tdm_slot_port_props.sv ====
// pin-level checks of the tdm slot port
module tdm_slot_port_props (
	input wire logic        hclk,               // clock
	input wire logic        hresetn,            // reset, low
	input wire logic        hsel,               // select
	input wire logic [1:0]  htrans,             // type
	input wire logic        hready,             // ready in
	input wire logic        hreadyout,          // ready out
	input wire logic [31:0] hrdata,             // read data
	input wire logic        hresp,              // response
	input wire logic        serial_bit_clock,   // bit clock
	input wire logic        serial_data_out,    // data out
	input wire logic        serial_data_out_en, // data enable
	input wire logic        bus_keeper_enable,  // keeper
	input wire logic [31:0] playback_sample,    // sample
	input wire logic        playback_valid      // strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// bit clock half period is 4 bus cycles, so one pin edge lies between 1 and 7 cycles back
	a_one_wait: assert property (hsel && htrans[1] && hready && hreadyout |=>
		!hreadyout ##1 hreadyout) else $error("transfer not one wait state");
	a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data moved outside a read");
	a_valid_pulse: assert property (playback_valid |=> !playback_valid)
		else $error("sample strobe too long");
	a_sample_hold: assert property (!playback_valid |-> $stable(playback_sample))
		else $error("sample moved without strobe");
	a_valid_edge: assert property (playback_valid |->
		$past(serial_bit_clock, 1) != $past(serial_bit_clock, 7)) else $error("strobe off edge");
	a_out_edge: assert property ($changed(serial_data_out) |->
		$past(serial_bit_clock, 1) != $past(serial_bit_clock, 7)) else $error("data off edge");
	a_en_edge: assert property ($changed(serial_data_out_en) |->
		$past(serial_bit_clock, 1) != $past(serial_bit_clock, 7)) else $error("enable off edge");
	a_keeper_reset: assert property ($rose(hresetn) |-> bus_keeper_enable)
		else $error("keeper off after reset");
endmodule

// ==== testbench/tdm_host_model.sv ====
// tdm bus master: makes bit clock, sync and data, records the returned line
module tdm_host_model (
	input  wire logic        run,                // frames run while high
	input  wire logic [63:0] rx_frame,           // frame bits, msb first
	input  wire logic        serial_data_out,    // device data
	input  wire logic        serial_data_out_en, // device drives
	input  wire logic        bus_keeper_enable,  // keeper on
	output logic             serial_bit_clock,   // bit clock
	output logic             frame_sync,         // frame sync
	output logic             serial_data_in,     // data to device
	output logic [63:0]      tx_frame,           // line of last frame
	output logic [63:0]      tx_en,              // enables of last frame
	output int               frames              // frame starts seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [63:0] sh;
	logic [63:0] she;
	logic        line;
	int          pos;
	// no keeper: flip the level so a held value is never taken for a driven one
	assign line = serial_data_out_en | bus_keeper_enable ? serial_data_out : ~serial_data_out;
	initial begin
		{serial_bit_clock, frame_sync, serial_data_in, sh, she, tx_frame, tx_en} = '0;
		{pos, frames} = '0;
		#37;
		forever begin
			if (run) begin
				// steady 64-bit frames, sync rises at bit 0
				frame_sync = pos < 32;
				serial_data_in = rx_frame[63 - pos];
				#160 serial_bit_clock = 1'b1;
				sh = {sh[62:0], line};
				she = {she[62:0], serial_data_out_en};
				if (pos == 0) begin
					tx_frame = sh;
					tx_en = she;
					frames++;
				end
				#160 serial_bit_clock = 1'b0;
				pos = (pos + 1) % 64;
			end else
				#40;
		end
	end
endmodule

// ==== testbench/tdm_slot_port_bench.sv ====
// self-checking bench of the tdm slot port
module tdm_slot_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, run;
	logic [31:0] haddr, hwdata, hrdata, playback_sample, rdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize, address_select;
	logic        serial_bit_clock, frame_sync, serial_data_in, serial_data_out;
	logic        serial_data_out_en, bus_keeper_enable, playback_valid;
	logic [63:0] rx_frame, tx_frame, tx_en;
	int          frames, fails, cmp_count;
	assign hready = hreadyout;
	tdm_slot_port DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hrdata, .hresp, .serial_bit_clock, .frame_sync,
		.serial_data_in, .address_select, .serial_data_out, .serial_data_out_en,
		.bus_keeper_enable, .playback_sample, .playback_valid);
	tdm_host_model host (.run, .rx_frame, .serial_data_out, .serial_data_out_en,
		.bus_keeper_enable, .serial_bit_clock, .frame_sync, .serial_data_in, .tx_frame,
		.tx_en, .frames);
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rdata = hrdata;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		check(what, {32'h0, rdata}, {32'h0, exp});
	endtask
	task automatic wait_frames(input int n);
		int f;
		f = frames + n;
		while (frames < f) @(posedge hclk);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rchk("rx cfg", 8'h00, 32'h0000_0506);
		rchk("tx cfg", 8'h04, 32'h0000_0033);
		rchk("tx slot", 8'h08, 32'h0604_0200);
		ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
		rchk("unmapped", 8'h40, 32'h0000_0000);
		check("keeper", {63'h0, bus_keeper_enable}, 64'h1);
	endtask
	task automatic t_receive();
		logic [31:0] cfg [5];
		logic [31:0] exp [5];
		cfg = '{32'h0000_1704, 32'h0000_1904, 32'h0000_0884, 32'h0004_3003, 32'h0000_5704};
		exp = '{rx_frame[62:31], {rx_frame[46:31], 16'h0000}, {rx_frame[30:15], 16'h0000},
			32'hBCD6_0000, 32'h0000_0000};
		for (int i = 0; i < 5; i++) begin
			ahb(1'b1, 8'h00, cfg[i]);
			wait_frames(3);
			// word, right 16, address slot, downmix, past end
			check("playback", {32'h0, playback_sample}, {32'h0, exp[i]});
		end
	endtask
	task automatic t_transmit();
		ahb(1'b1, 8'h10, 32'h0000_A5C3);
		ahb(1'b1, 8'h18, 32'h0000_003C);
		ahb(1'b1, 8'h08, 32'h0604_0202);
		ahb(1'b1, 8'h04, 32'h0000_0880);
		repeat (2) @(posedge hclk);
		check("keeper", {63'h0, bus_keeper_enable}, 64'h0);
		wait_frames(3);
		check("tx data", tx_frame, 64'h0000_A5C3_0000_003C);
		check("tx drive", tx_en, 64'hFFFF_FFFF_FFFF_FFFF);
		ahb(1'b1, 8'h14, 32'h0ABC_0000);
		ahb(1'b1, 8'h08, 32'h0004_0207);
		ahb(1'b1, 8'h04, 32'h0000_04B1);
		wait_frames(3);
		// falling launch, supply top byte, voltage cut at frame end
		check("tx cut", {48'h0, tx_frame[63:56], tx_frame[7:0]}, 64'hABA5);
		check("tx float", tx_en, 64'hFF00_0000_0000_00FF);
	endtask
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, run, htrans, haddr, hwdata} = '0;
		{hsize, address_select} = {3'b010, 3'h1};
		rx_frame = 64'h1234_5678_9ABC_DEF0;
		{fails, cmp_count} = '0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		run <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_receive();
		t_transmit();
		end_sim();
	end
	initial begin
		#1ms;
		fails++;
		end_sim();
	end
endmodule
bind tdm_slot_port tdm_slot_port_props chk (.hclk, .hresetn, .hsel, .htrans, .hready,
	.hreadyout, .hrdata, .hresp, .serial_bit_clock, .serial_data_out, .serial_data_out_en,
	.bus_keeper_enable, .playback_sample, .playback_valid);
